// ==== hdl/mcr_top.sv ====
`timescale 1ns/1ps
//
// Summary of operation
// - Reactive offset added to averaged reactive power.
// - Reactive offset is signed Q1.23 fraction.
// - Both current AC offsets reset to zero.
// - AC offset unsigned, LSB weighs 2^-24.
// - AC offset corrects only the mean square.
// - Temperature scaled by unsigned Q8.16 gain.
// - Temperature offset by signed Q8.16 offset.
// - Gain calibration writes scale over RMS.
// - Scale word sets calibrated RMS target level.
// - Voltage crossings only above voltage threshold.
// - Current crossings only above current threshold.
// - Line frequency over programmed crossing count.
// - AC calibration stores squared residual RMS.
//
module mcr_top
   import mcr_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESETN,
   // AHB-Lite slave.
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Averaged reactive power per channel, before offset.
   input wire logic [23:0] REACTIVE1_AVERAGE_RAW,
   input wire logic [23:0] REACTIVE2_AVERAGE_RAW,
   output logic [23:0] REACTIVE1_AVERAGE_RESULT,
   output logic [23:0] REACTIVE2_AVERAGE_RESULT,
   // Mean square of each current channel, before AC offset removal.
   input wire logic [23:0] CURRENT1_MEAN_SQUARE,
   input wire logic [23:0] CURRENT2_MEAN_SQUARE,
   output logic [23:0] CURRENT1_MEAN_SQUARE_CORRECTED,
   output logic [23:0] CURRENT2_MEAN_SQUARE_CORRECTED,
   // Raw temperature and its corrected value.
   input wire logic [23:0] TEMPERATURE_RAW,
   output logic [23:0] TEMPERATURE_RESULT,
   // Calibration requests from the calibration sequencer.
   input wire logic AC_CAL_START,
   input wire logic GAIN_CAL_START,
   input wire logic CAL_CHANNEL,
   input wire logic [23:0] CURRENT_RMS_RESULT,
   output logic GAIN_CAL_BUSY,
   output logic CURRENT_GAIN_WRITE,
   output logic CURRENT_GAIN_CHANNEL,
   output logic [23:0] CURRENT_GAIN_WORD,
   // Zero-crossing qualification and line frequency measurement.
   input wire logic [23:0] VOLTAGE_PEAK,
   input wire logic [23:0] CURRENT_PEAK,
   input wire logic VOLTAGE_CROSSING,
   input wire logic SAMPLE_STROBE,
   output logic VOLTAGE_CROSSING_ENABLE,
   output logic CURRENT_CROSSING_ENABLE,
   output logic [31:0] LINE_PERIOD_SAMPLES,
   output logic LINE_PERIOD_VALID
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // State of the block, held as one packed struct.

   typedef struct packed
   {
      logic [23:0] zero_cross_count;
      logic [1:0][23:0] current_ac_offset;
      logic [1:0][23:0] reactive_avg_offset;
      logic [23:0] temperature_gain;
      logic [23:0] temperature_offset;
      logic [23:0] current_crossing_threshold;
      logic [23:0] voltage_crossing_threshold;
      logic [23:0] calibration_scale;
      logic ph_valid;
      logic ph_write;
      logic [4:0] ph_page;
      logic [5:0] ph_index;
      logic [31:0] hrdata;
      logic hreadyout;
      logic [1:0][23:0] reactive_result;
      logic [1:0][23:0] ms_corrected;
      logic [23:0] temp_result;
      logic div_busy;
      logic div_chan;
      logic [5:0] div_steps;
      logic [46:0] div_num;
      logic [46:0] div_quot;
      logic [24:0] div_rem;
      logic [23:0] div_den;
      logic gain_write;
      logic gain_chan;
      logic [23:0] gain_word;
      logic v_enable;
      logic i_enable;
      logic [23:0] crossings;
      logic [31:0] sample_count;
      logic [31:0] period;
      logic period_valid;
   } mcr_state_t;

   // Registered state and its next value.
   mcr_state_t state;
   mcr_state_t next_state;

   // Per-channel inputs gathered for indexed use.
   logic [1:0][23:0] raw_q;
   logic [1:0][23:0] raw_ms;
   // Per-channel combinational results.
   logic [1:0][23:0] sum_q;
   logic [1:0][23:0] diff_ms;

   assign raw_q[0] = REACTIVE1_AVERAGE_RAW;
   assign raw_q[1] = REACTIVE2_AVERAGE_RAW;
   assign raw_ms[0] = CURRENT1_MEAN_SQUARE;
   assign raw_ms[1] = CURRENT2_MEAN_SQUARE;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Per-channel corrections from the live offsets.

   genvar ch;
   generate
      for (ch = 0; ch < MCR_CH; ch++)
      begin : g_chan
         // One guard bit catches overflow of the signed Q1.23 sum.
         logic [24:0] q_wide;
         assign q_wide = {raw_q[ch][23], raw_q[ch]}
            + {state.reactive_avg_offset[ch][23], state.reactive_avg_offset[ch]};
         // Saturate instead of wrapping so a large offset cannot flip the sign.
         assign sum_q[ch] = (q_wide[24] == q_wide[23]) ? q_wide[23:0]
            : (q_wide[24] ? MCR_SAT_NEG : MCR_SAT_POS);
         // The AC offset is removed from the squared value only and floors at zero.
         assign diff_ms[ch] = (raw_ms[ch] >= state.current_ac_offset[ch])
            ? raw_ms[ch] - state.current_ac_offset[ch] : '0;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb
   begin
      logic [48:0] t_prod;
      logic [24:0] t_scaled;
      logic [24:0] t_sum;
      logic [47:0] sq;
      logic [24:0] trial;
      logic [23:0] wdata;
      logic [23:0] rdval;
      logic [23:0] target;
      logic take;
      t_prod = '0;
      t_scaled = '0;
      t_sum = '0;
      sq = '0;
      trial = '0;
      wdata = '0;
      rdval = '0;
      target = '0;
      take = 1'b0;
      next_state = state;

      // Data phase of a write: store the low 24 bits of the word.
      wdata = HWDATA[23:0];
      if (state.ph_valid && state.ph_write)
      begin
         unique case ({state.ph_page, state.ph_index})
            {MCR_PAGE_0, MCR_IDX_ZERO_CROSS_COUNT}:
               next_state.zero_cross_count = wdata;
            {MCR_PAGE_16, MCR_IDX_CURRENT1_AC_OFFSET}:
               next_state.current_ac_offset[0] = wdata;
            {MCR_PAGE_16, MCR_IDX_CURRENT2_AC_OFFSET}:
               next_state.current_ac_offset[1] = wdata;
            {MCR_PAGE_16, MCR_IDX_REACTIVE1_AVG_OFFSET}:
               next_state.reactive_avg_offset[0] = wdata;
            {MCR_PAGE_16, MCR_IDX_REACTIVE2_AVG_OFFSET}:
               next_state.reactive_avg_offset[1] = wdata;
            {MCR_PAGE_16, MCR_IDX_TEMPERATURE_GAIN}:
               next_state.temperature_gain = wdata;
            {MCR_PAGE_16, MCR_IDX_TEMPERATURE_OFFSET}:
               next_state.temperature_offset = wdata;
            {MCR_PAGE_18, MCR_IDX_CURRENT_CROSSING_THRESHOLD}:
               next_state.current_crossing_threshold = wdata;
            {MCR_PAGE_18, MCR_IDX_VOLTAGE_CROSSING_THRESHOLD}:
               next_state.voltage_crossing_threshold = wdata;
            {MCR_PAGE_18, MCR_IDX_CALIBRATION_SCALE}:
               next_state.calibration_scale = wdata;
            // Unmapped addresses swallow the write.
            default:
            begin
            end
         endcase
      end

      // AC offset calibration overrides a same-cycle software write.
      sq = CURRENT_RMS_RESULT * CURRENT_RMS_RESULT;
      if (AC_CAL_START)
      begin
         next_state.current_ac_offset[CAL_CHANNEL] = sq[47:24];
      end

      // Address phase: read data come from the next values,
      // so a write just before is seen.
      take = HSEL && HREADY && HTRANS[MCR_HTRANS_ACTIVE];
      next_state.ph_valid = take;
      next_state.ph_write = HWRITE;
      next_state.ph_page = HADDR[MCR_PAGE_MSB:MCR_PAGE_LSB];
      next_state.ph_index = HADDR[MCR_IDX_MSB:MCR_IDX_LSB];
      unique case ({HADDR[MCR_PAGE_MSB:MCR_PAGE_LSB], HADDR[MCR_IDX_MSB:MCR_IDX_LSB]})
         {MCR_PAGE_0, MCR_IDX_ZERO_CROSS_COUNT}: rdval = next_state.zero_cross_count;
         {MCR_PAGE_16, MCR_IDX_CURRENT1_AC_OFFSET}: rdval = next_state.current_ac_offset[0];
         {MCR_PAGE_16, MCR_IDX_CURRENT2_AC_OFFSET}: rdval = next_state.current_ac_offset[1];
         {MCR_PAGE_16, MCR_IDX_REACTIVE1_AVG_OFFSET}: rdval = next_state.reactive_avg_offset[0];
         {MCR_PAGE_16, MCR_IDX_REACTIVE2_AVG_OFFSET}: rdval = next_state.reactive_avg_offset[1];
         {MCR_PAGE_16, MCR_IDX_TEMPERATURE_GAIN}: rdval = next_state.temperature_gain;
         {MCR_PAGE_16, MCR_IDX_TEMPERATURE_OFFSET}: rdval = next_state.temperature_offset;
         {MCR_PAGE_18, MCR_IDX_CURRENT_CROSSING_THRESHOLD}:
            rdval = next_state.current_crossing_threshold;
         {MCR_PAGE_18, MCR_IDX_VOLTAGE_CROSSING_THRESHOLD}:
            rdval = next_state.voltage_crossing_threshold;
         {MCR_PAGE_18, MCR_IDX_CALIBRATION_SCALE}: rdval = next_state.calibration_scale;
         // Unmapped addresses read as zero.
         default: rdval = '0;
      endcase
      if (take && !HWRITE)
      begin
         next_state.hrdata = {8'h00, rdval};
      end
      // The slave never inserts wait states.
      next_state.hreadyout = 1'b1;

      // Registered channel results.
      next_state.reactive_result = sum_q;
      next_state.ms_corrected = diff_ms;

      // Temperature: signed Q8.16 times unsigned Q8.16, back to Q8.16.
      t_prod = $signed(TEMPERATURE_RAW) * $signed({1'b0, state.temperature_gain});
      if (t_prod[48:39] == {10{t_prod[39]}})
      begin
         t_scaled = {t_prod[39], t_prod[39:16]};
      end
      else
      begin
         // Product out of range: clamp before the offset is added.
         t_scaled = t_prod[48] ? {1'b1, MCR_SAT_NEG} : {1'b0, MCR_SAT_POS};
      end
      t_sum = t_scaled + {state.temperature_offset[23], state.temperature_offset};
      next_state.temp_result = (t_sum[24] == t_sum[23]) ? t_sum[23:0]
         : (t_sum[24] ? MCR_SAT_NEG : MCR_SAT_POS);

      // Gain calibration: restoring division of scale by the measured RMS.
      next_state.gain_write = 1'b0;
      if (!state.div_busy && GAIN_CAL_START)
      begin
         next_state.div_busy = 1'b1;
         next_state.div_chan = CAL_CHANNEL;
         next_state.div_steps = MCR_DIV_STEPS;
         // Negative scale values are unused.
         next_state.div_num = {state.calibration_scale, 23'h000000};
         next_state.div_den = CURRENT_RMS_RESULT;
         next_state.div_rem = '0;
         next_state.div_quot = '0;
      end
      else if (state.div_busy)
      begin
         if (state.div_steps != 6'd0)
         begin
            trial = {state.div_rem[23:0], state.div_num[46]};
            next_state.div_num = {state.div_num[45:0], 1'b0};
            if (trial >= {1'b0, state.div_den})
            begin
               next_state.div_rem = trial - {1'b0, state.div_den};
               next_state.div_quot = {state.div_quot[45:0], 1'b1};
            end
            else
            begin
               next_state.div_rem = trial;
               next_state.div_quot = {state.div_quot[45:0], 1'b0};
            end
            next_state.div_steps = state.div_steps - 6'd1;
         end
         else
         begin
            // Gain of four or more or a zero RMS saturates rather than wrapping.
            next_state.div_busy = 1'b0;
            next_state.gain_write = 1'b1;
            next_state.gain_chan = state.div_chan;
            next_state.gain_word = (state.div_den == '0 || state.div_quot[46:24] != '0)
               ? MCR_SAT_UNS : state.div_quot[23:0];
         end
      end

      // Crossing detection is qualified by the peak level (signed compare).
      next_state.v_enable = $signed(VOLTAGE_PEAK)
         > $signed(state.voltage_crossing_threshold);
      next_state.i_enable = $signed(CURRENT_PEAK)
         > $signed(state.current_crossing_threshold);

      // Line period: samples elapsed over the programmed number of crossings.
      // A programmed zero is run as one so the counter can never stall.
      target = (state.zero_cross_count == '0) ? 24'h000001 : state.zero_cross_count;
      next_state.period_valid = 1'b0;
      if (SAMPLE_STROBE)
      begin
         next_state.sample_count = state.sample_count + 32'h00000001;
      end
      if (VOLTAGE_CROSSING && state.v_enable)
      begin
         if (state.crossings + 24'h000001 >= target)
         begin
            next_state.period = next_state.sample_count;
            next_state.period_valid = 1'b1;
            next_state.crossings = '0;
            next_state.sample_count = '0;
         end
         else
         begin
            next_state.crossings = state.crossings + 24'h000001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // State register; asynchronous reset to the defaults.

   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state <= '0;
         state.zero_cross_count <= MCR_RST_ZERO_CROSS_COUNT;
         state.current_ac_offset <= {MCR_RST_AC_OFFSET, MCR_RST_AC_OFFSET};
         state.reactive_avg_offset <= {MCR_RST_REACTIVE_OFFSET, MCR_RST_REACTIVE_OFFSET};
         state.temperature_gain <= MCR_RST_TEMPERATURE_GAIN;
         state.temperature_offset <= MCR_RST_TEMPERATURE_OFFSET;
         state.current_crossing_threshold <= MCR_RST_CROSSING_THRESHOLD;
         state.voltage_crossing_threshold <= MCR_RST_CROSSING_THRESHOLD;
         state.calibration_scale <= MCR_RST_CALIBRATION_SCALE;
         state.hreadyout <= 1'b1;
      end
      else
      begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Outputs other than HRESP straight from the state register.

   assign HRDATA = state.hrdata;
   assign HREADYOUT = state.hreadyout;
   assign HRESP = 1'b0;
   assign REACTIVE1_AVERAGE_RESULT = state.reactive_result[0];
   assign REACTIVE2_AVERAGE_RESULT = state.reactive_result[1];
   assign CURRENT1_MEAN_SQUARE_CORRECTED = state.ms_corrected[0];
   assign CURRENT2_MEAN_SQUARE_CORRECTED = state.ms_corrected[1];
   assign TEMPERATURE_RESULT = state.temp_result;
   assign GAIN_CAL_BUSY = state.div_busy;
   assign CURRENT_GAIN_WRITE = state.gain_write;
   assign CURRENT_GAIN_CHANNEL = state.gain_chan;
   assign CURRENT_GAIN_WORD = state.gain_word;
   assign VOLTAGE_CROSSING_ENABLE = state.v_enable;
   assign CURRENT_CROSSING_ENABLE = state.i_enable;
   assign LINE_PERIOD_SAMPLES = state.period;
   assign LINE_PERIOD_VALID = state.period_valid;

endmodule

// ==== hdl/mcr_pkg.sv ====
// Shared constants for the meter correction register bank.
package mcr_pkg;

   // Data width of every correction word.
   localparam int MCR_W = 24;
   // Number of current/reactive channels.
   localparam int MCR_CH = 2;

   // Byte address layout: page in [12:8], register index in [7:2].
   localparam int MCR_ADDR_W = 13;
   localparam int MCR_PAGE_LSB = 8;
   localparam int MCR_PAGE_MSB = 12;
   localparam int MCR_IDX_LSB = 2;
   localparam int MCR_IDX_MSB = 7;

   // Pages holding the bank.
   localparam logic [4:0] MCR_PAGE_0 = 5'h00;
   localparam logic [4:0] MCR_PAGE_16 = 5'h10;
   localparam logic [4:0] MCR_PAGE_18 = 5'h12;

   // Register indices within a page; byte address is four times the index.
   localparam logic [5:0] MCR_IDX_ZERO_CROSS_COUNT = 6'h37;
   localparam logic [5:0] MCR_IDX_CURRENT1_AC_OFFSET = 6'h25;
   localparam logic [5:0] MCR_IDX_REACTIVE1_AVG_OFFSET = 6'h26;
   localparam logic [5:0] MCR_IDX_CURRENT2_AC_OFFSET = 6'h2C;
   localparam logic [5:0] MCR_IDX_REACTIVE2_AVG_OFFSET = 6'h2D;
   localparam logic [5:0] MCR_IDX_TEMPERATURE_GAIN = 6'h36;
   localparam logic [5:0] MCR_IDX_TEMPERATURE_OFFSET = 6'h37;
   localparam logic [5:0] MCR_IDX_CURRENT_CROSSING_THRESHOLD = 6'h18;
   localparam logic [5:0] MCR_IDX_VOLTAGE_CROSSING_THRESHOLD = 6'h3A;
   localparam logic [5:0] MCR_IDX_CALIBRATION_SCALE = 6'h3F;

   // Reset values.
   localparam logic [23:0] MCR_RST_ZERO_CROSS_COUNT = 24'h000064;
   localparam logic [23:0] MCR_RST_AC_OFFSET = 24'h000000;
   localparam logic [23:0] MCR_RST_REACTIVE_OFFSET = 24'h000000;
   localparam logic [23:0] MCR_RST_TEMPERATURE_GAIN = 24'h06B716;
   localparam logic [23:0] MCR_RST_TEMPERATURE_OFFSET = 24'hD53998;
   localparam logic [23:0] MCR_RST_CROSSING_THRESHOLD = 24'h100000;
   localparam logic [23:0] MCR_RST_CALIBRATION_SCALE = 24'h4CCCCC;

   // Signed and unsigned saturation limits of a 24-bit word.
   localparam logic [23:0] MCR_SAT_POS = 24'h7FFFFF;
   localparam logic [23:0] MCR_SAT_NEG = 24'h800000;
   localparam logic [23:0] MCR_SAT_UNS = 24'hFFFFFF;

   // Fixed-point positions: temperature words carry 16 fraction bits.
   localparam int MCR_TEMP_FRAC = 16;
   // Gain quotient: scale (Q1.23) over rms (Q0.24) into Q2.22 needs 23 extra bits.
   localparam int MCR_DIV_SHIFT = 23;
   localparam int MCR_DIV_NUM_W = 47;
   localparam logic [5:0] MCR_DIV_STEPS = 6'd47;

   // Width of the line-period sample counter.
   localparam int MCR_PER_W = 32;

   // AHB transfer type bit that marks NONSEQ or SEQ.
   localparam int MCR_HTRANS_ACTIVE = 1;

endpackage

// ==== testbench/mcr_top_assertions.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Port-level checker; it only looks.
module mcr_top_checker
   import mcr_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic HSEL,
   input wire logic HREADY,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic [23:0] CURRENT1_MEAN_SQUARE,
   input wire logic [23:0] CURRENT2_MEAN_SQUARE,
   input wire logic [23:0] CURRENT1_MEAN_SQUARE_CORRECTED,
   input wire logic [23:0] CURRENT2_MEAN_SQUARE_CORRECTED,
   input wire logic GAIN_CAL_START,
   input wire logic GAIN_CAL_BUSY,
   input wire logic CURRENT_GAIN_WRITE,
   input wire logic VOLTAGE_CROSSING,
   input wire logic VOLTAGE_CROSSING_ENABLE,
   input wire logic LINE_PERIOD_VALID
);
   // One clock domain; checks drop out in reset.
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESETN);

   ////////////////////////////////////////////////////////////
   // Bus side: zero wait, always OKAY, only 24 data bits ever come back.
   a_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus wait or error");
   a_rdata_width: assert property (HRDATA[31:24] == 8'h00)
      else $error("read data above bit 23");
   // Read data may only move when a read address phase was taken.
   a_rdata_hold: assert property (!$past(HSEL && HREADY && HTRANS[1] && !HWRITE)
      |-> $stable(HRDATA))
      else $error("read data changed without a read");

   ////////////////////////////////////////////////////////////
   // Gain calibration: result exactly 49 cycles after start.
   a_gain_latency: assert property (GAIN_CAL_START && !GAIN_CAL_BUSY
      |-> ##49 CURRENT_GAIN_WRITE)
      else $error("gain result late");
   a_busy_hold: assert property (GAIN_CAL_START && !GAIN_CAL_BUSY
      |=> GAIN_CAL_BUSY [*8])
      else $error("busy not held");
   a_write_pulse: assert property (CURRENT_GAIN_WRITE |=> !CURRENT_GAIN_WRITE)
      else $error("gain write too long");
   a_busy_drop: assert property (CURRENT_GAIN_WRITE
      |-> !GAIN_CAL_BUSY && $past(GAIN_CAL_BUSY))
      else $error("busy stuck at gain write");

   ////////////////////////////////////////////////////////////
   // A period result only follows a qualified crossing.
   a_period_cause: assert property (LINE_PERIOD_VALID
      |-> $past(VOLTAGE_CROSSING && VOLTAGE_CROSSING_ENABLE))
      else $error("period without crossing");
   // Removing a non-negative offset can never raise the mean square.
   a_ms_bounded: assert property (CURRENT1_MEAN_SQUARE_CORRECTED <= $past(CURRENT1_MEAN_SQUARE)
      && CURRENT2_MEAN_SQUARE_CORRECTED <= $past(CURRENT2_MEAN_SQUARE))
      else $error("mean square rose");

   // Main scenarios.
   c_gain_write: cover property (CURRENT_GAIN_WRITE);
   c_period: cover property (LINE_PERIOD_VALID);
   c_read: cover property (HSEL && HREADY && HTRANS[1] && !HWRITE);
endmodule

// ==== testbench/mcr_top_tb_top.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Self-checking bench, one task per scenario.
module mcr_top_tb_top
   import mcr_pkg::*;
();
   localparam int LIMIT = 5000;
   // Byte addresses and reset values, in the same order.
   localparam logic [31:0] RA [10] = '{32'h00DC, 32'h1094, 32'h1098, 32'h10B0, 32'h10B4,
      32'h10D8, 32'h10DC, 32'h1260, 32'h12E8, 32'h12FC};
   localparam logic [23:0] RV [10] = '{24'h000064, 24'h000000, 24'h000000, 24'h000000,
      24'h000000, 24'h06B716, 24'hD53998, 24'h100000, 24'h100000, 24'h4CCCCC};
   logic clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, busy, gwrite, gchan, ven, cen, pvalid;
   logic [23:0] r1 = 24'h0, r2 = 24'h0, m1 = 24'h0, m2 = 24'h0, traw = 24'h0, rms = 24'h0;
   logic [23:0] vpeak = 24'h0, ipeak = 24'h0, r1o, r2o, m1o, m2o, tres, gword;
   logic ac_start = 1'b0, g_start = 1'b0, cal_ch = 1'b0, vcross = 1'b0, strobe = 1'b0;
   logic [31:0] period;
   int errors = 0, tests_run = 0, cycles = 0;

   // The one slave's ready is the bus ready.
   assign hready = hreadyout;
   always #12.5 clk_sys = ~clk_sys;

   mcr_top mcr_top_inst (.CLK_SYS(clk_sys), .RESETN(rst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .REACTIVE1_AVERAGE_RAW(r1), .REACTIVE2_AVERAGE_RAW(r2),
      .REACTIVE1_AVERAGE_RESULT(r1o), .REACTIVE2_AVERAGE_RESULT(r2o),
      .CURRENT1_MEAN_SQUARE(m1), .CURRENT2_MEAN_SQUARE(m2),
      .CURRENT1_MEAN_SQUARE_CORRECTED(m1o), .CURRENT2_MEAN_SQUARE_CORRECTED(m2o),
      .TEMPERATURE_RAW(traw), .TEMPERATURE_RESULT(tres), .AC_CAL_START(ac_start),
      .GAIN_CAL_START(g_start), .CAL_CHANNEL(cal_ch), .CURRENT_RMS_RESULT(rms),
      .GAIN_CAL_BUSY(busy), .CURRENT_GAIN_WRITE(gwrite), .CURRENT_GAIN_CHANNEL(gchan),
      .CURRENT_GAIN_WORD(gword), .VOLTAGE_PEAK(vpeak), .CURRENT_PEAK(ipeak),
      .VOLTAGE_CROSSING(vcross), .SAMPLE_STROBE(strobe), .VOLTAGE_CROSSING_ENABLE(ven),
      .CURRENT_CROSSING_ENABLE(cen), .LINE_PERIOD_SAMPLES(period), .LINE_PERIOD_VALID(pvalid));

   ////////////////////////////////////////////////////////////
   // Counts, verdict, end of run.
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // A hang counts as a mismatch.
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         errors = errors + 1;
         give_verdict();
      end
   end

   // Case equality, so an unknown output never passes for a match.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // One AHB-Lite transfer: each phase held until ready is high; data at the end.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask

   ////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic test_resets();
      for (int i = 0; i < 10; i++)
         rd_chk(RA[i], {8'h00, RV[i]});
      $display("reset values done");
   endtask

   // A negative offset lowers channel 1; a full-scale offset saturates channel 2.
   task automatic test_reactive();
      wr(RA[2], 32'h00FFFFF0);
      wr(RA[4], 32'h007FFFFF);
      r1 <= 24'h000100;
      r2 <= 24'h000001;
      tick(2);
      check(32'(r1o), 32'h000000F0);
      check(32'(r2o), 32'h007FFFFF);
      $display("reactive offset done");
   endtask

   // The offset is removed from the mean square and clamps at zero.
   task automatic test_mean_square();
      wr(RA[1], 32'h00000100);
      wr(RA[3], 32'h00000400);
      m1 <= 24'h000300;
      m2 <= 24'h000050;
      tick(2);
      check(32'(m1o), 32'h00000200);
      check(32'(m2o), 32'h00000000);
      $display("ac offset done");
   endtask

   // Gain 2.0 and offset -1.0; the second case saturates the product first.
   task automatic test_temperature();
      wr(RA[5], 32'h00020000);
      wr(RA[6], 32'h00FF0000);
      traw <= 24'h030000;
      tick(2);
      check(32'(tres), 32'h00050000);
      traw <= 24'h7F0000;
      tick(2);
      check(32'(tres), 32'h007EFFFF);
      $display("temperature done");
   endtask

   // One division; a second start while busy must be ignored.
   task automatic gcal(input logic ch, input logic [23:0] r, input logic [23:0] exp);
      cal_ch <= ch;
      rms <= r;
      g_start <= 1'b1;
      tick(1);
      g_start <= 1'b0;
      tick(5);
      check(32'(busy), 32'h1);
      rms <= 24'h000001;
      g_start <= 1'b1;
      tick(1);
      g_start <= 1'b0;
      // The write pulse stands between the 48th and 49th edge after the start.
      tick(43);
      check(32'(gwrite), 32'h1);
      check(32'(gword), 32'(exp));
      check(32'(gchan), 32'(ch));
   endtask

   task automatic test_gain();
      gcal(1'b0, 24'h400000, 24'h999998);
      gcal(1'b1, 24'h000000, 24'hFFFFFF);
      wr(RA[9], 32'h00266666);
      gcal(1'b1, 24'h400000, 24'h4CCCCC);
      $display("gain calibration done");
   endtask

   // Two back-to-back offset calibrations, one per channel.
   task automatic test_ac_cal();
      ac_start <= 1'b1;
      cal_ch <= 1'b0;
      rms <= 24'h001000;
      tick(1);
      cal_ch <= 1'b1;
      rms <= 24'h800000;
      tick(1);
      ac_start <= 1'b0;
      rd_chk(RA[1], 32'h00000001);
      rd_chk(RA[3], 32'h00400000);
      $display("ac calibration done");
   endtask

   // Peaks exactly at the threshold do not qualify; one step above does.
   task automatic test_thresholds();
      vpeak <= 24'h100001;
      ipeak <= 24'h100000;
      tick(2);
      check(32'(ven), 32'h1);
      check(32'(cen), 32'h0);
      vpeak <= 24'h100000;
      ipeak <= 24'h100001;
      tick(2);
      check(32'(ven), 32'h0);
      check(32'(cen), 32'h1);
      $display("thresholds done");
   endtask

   // Count of two: an unqualified crossing is skipped, six strobes are counted.
   task automatic test_period();
      wr(RA[0], 32'h00000002);
      vpeak <= 24'h000000;
      tick(2);
      vcross <= 1'b1;
      tick(1);
      vcross <= 1'b0;
      vpeak <= 24'h200000;
      tick(2);
      vcross <= 1'b1;
      tick(1);
      vcross <= 1'b0;
      strobe <= 1'b1;
      tick(5);
      vcross <= 1'b1;
      tick(1);
      vcross <= 1'b0;
      strobe <= 1'b0;
      tick(1);
      check(32'(pvalid), 32'h1);
      check(period, 32'h00000006);
      $display("line period done");
   endtask

   // Every register keeps only its 24 bits; an unmapped word stays zero.
   task automatic test_read_write();
      logic [31:0] d;
      for (int i = 0; i < 10; i++)
      begin
         d = 32'hA55A5A00 + 32'(i);
         wr(RA[i], d);
         rd_chk(RA[i], {8'h00, d[23:0]});
      end
      wr(32'h00001000, 32'h00123456);
      rd_chk(32'h00001000, 32'h00000000);
      $display("read write done");
   endtask

   ////////////////////////////////////////////////////////////
   // Reset for 16 cycles, then each scenario.
   initial
   begin
      tick(16);
      rst_n <= 1'b1;
      test_resets();
      test_reactive();
      test_mean_square();
      test_temperature();
      test_gain();
      test_ac_cal();
      test_thresholds();
      test_period();
      test_read_write();
      give_verdict();
   end
endmodule

bind mcr_top mcr_top_checker mcr_top_checker_inst (.CLK_SYS, .RESETN, .HSEL, .HREADY, .HTRANS,
   .HWRITE, .HRDATA, .HREADYOUT, .HRESP, .CURRENT1_MEAN_SQUARE, .CURRENT2_MEAN_SQUARE,
   .CURRENT1_MEAN_SQUARE_CORRECTED, .CURRENT2_MEAN_SQUARE_CORRECTED, .GAIN_CAL_START,
   .GAIN_CAL_BUSY, .CURRENT_GAIN_WRITE, .VOLTAGE_CROSSING, .VOLTAGE_CROSSING_ENABLE,
   .LINE_PERIOD_VALID);
